/* rtl/label_cmp_pkg.sv */
// Functional notes
// - Each flow holds one select bit choosing next-protocol set A or B.
// - Two identical next-protocol sets let one engine act as two engines.
// - Flows split freely between the two sets, eight flows at most.
// - Walk the stack label by label, counting, to find the next protocol.
// - Stacks of one to four labels, each label one 32-bit word.
// - Per-flow bit says whether a 32-bit control word follows the stack.
// - Expected control word passes only if its top four bits are zero.
// - Only match mode and next pointer are shared; the rest is per flow.
// - Two 3-bit shared pointers, one per set (A and B), name the comparator after the stack.
// - Per-flow channel mask bit: 1 applies the flow, 0 ignores it.
// - Reference bit: 0 searches from stack top, 1 from stack end.
// - 4-bit depth mask: bit n allows a stack of n+1 labels.
// - Tags and LLC/SNAP are parsed upstream; this stage sees labels and CW.
// - Four 20-bit low/high limit pairs per flow; label must lie within.
// - Top reference checks labels 0..3 from top; end reference the last four.
// - Next-protocol offset follows label count plus control word if present.
package label_cmp_pkg;
  localparam int NUM_FLOWS = 8;
  localparam int NUM_CHAN = 2;
  localparam int MAX_DEPTH = 4;
  localparam int ADDR_W = 12;
  localparam logic [11:0] GLOBAL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] FLOW_CFG_BASE = 12'h040;
  localparam logic [11:0] RANGE_BASE = 12'h100;
  localparam int PTR_A_LSB = 0;
  localparam int PTR_B_LSB = 4;
  localparam int RANGE_EN_BIT = 8;
  localparam int ST_DEPTH_LSB = 0;
  localparam int ST_MATCH_LSB = 8;
  localparam int ST_BUSY_BIT = 16;
  localparam int CW_CHECK_LSB = 28;
  localparam logic [31:0] GLOBAL_RST = 32'h0000_0100;
  localparam logic [31:0] FLOW_CFG_RST = 32'h0000_0000;
  localparam logic [19:0] RANGE_LOW_RST = 20'h00000;
  localparam logic [19:0] RANGE_HIGH_RST = 20'hFFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [19:0] value;
    logic [2:0] class_f;
    logic bos;
    logic [7:0] ttl;
  } label_word_s;

  typedef struct packed {
    logic [NUM_CHAN-1:0] chan_mask;
    logic [3:0] depth_mask;
    logic ref_end;
    logic grp_b;
    logic cw_exp;
    logic enable;
  } flow_cfg_s;

  localparam int FLOW_CFG_W = $bits(flow_cfg_s);

  typedef struct packed {
    logic [NUM_FLOWS-1:0][4:0] offset;
    logic [2:0] depth;
    logic [2:0] ptr_b;
    logic [2:0] ptr_a;
    logic [NUM_FLOWS-1:0] group_b;
    logic [NUM_FLOWS-1:0] match;
  } result_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LABEL = 2'b01,
    ST_CTRL = 2'b10
  } walk_state_e;
endpackage : label_cmp_pkg

/* rtl/mpls_label_stack_comparator.sv */
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
module mpls_label_stack_comparator
  import label_cmp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Word stream from the upstream stage
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic [$clog2(NUM_CHAN)-1:0] in_channel,
  input wire logic [31:0] in_data,
  // Result to the next stage
  output result_s result,
  output logic result_valid
);

  localparam int CH_W = $clog2(NUM_CHAN);

  // Configuration
  logic [2:0] ptr_a_ff;
  logic [2:0] ptr_b_ff;
  logic range_en_ff;
  flow_cfg_s flow_cfg_ff [NUM_FLOWS];
  logic [19:0] range_ff [NUM_FLOWS*MAX_DEPTH*2];

  // Walk state
  walk_state_e state_ff, nxt_state;
  logic [2:0] cnt_ff, depth_ff;
  logic [19:0] lbl_ff [MAX_DEPTH];
  logic [CH_W-1:0] chan_ff;
  logic cw_seen_ff, cw_ok_ff, eval_ff;
  result_s res_ff;
  logic res_valid_ff;

  // Bus state
  logic awready_ff, wready_ff, aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;

  function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return m;
  endfunction : strb_merge

  // Stream decode
  label_word_s word;
  logic take_first, take_label, take_ctrl, lbl_take;
  logic [2:0] lbl_pos;
  logic stack_end, stack_ovf, need_cw, finish;
  logic [CH_W-1:0] ch_now;
  logic [NUM_FLOWS-1:0] cw_need_vec;

  assign word = label_word_s'(in_data);
  // A start word is always the top label; upstream owns tags and LLC/SNAP
  assign take_first = in_valid & in_sop;
  assign take_label = in_valid & ~in_sop & (state_ff == ST_LABEL);
  assign take_ctrl = in_valid & ~in_sop & (state_ff == ST_CTRL);
  assign lbl_take = take_first | take_label;
  assign lbl_pos = take_first ? 3'd0 : cnt_ff;
  assign stack_end = lbl_take & word.bos;
  assign stack_ovf = lbl_take & ~word.bos &
                     (lbl_pos == 3'(MAX_DEPTH - 1));
  assign ch_now = take_first ? in_channel : chan_ff;
  // Control word is consumed if any applicable flow expects one
  assign need_cw = |cw_need_vec;
  assign finish = (stack_end & ~need_cw) | stack_ovf | take_ctrl;
  assign nxt_state = (stack_ovf | (stack_end & ~need_cw)) ? ST_IDLE :
                     stack_end ? ST_CTRL :
                     take_first ? ST_LABEL :
                     take_ctrl ? ST_IDLE : state_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'd0;
      depth_ff <= 3'd0;
      chan_ff <= '0;
      cw_seen_ff <= 1'b0;
      cw_ok_ff <= 1'b0;
      eval_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      eval_ff <= finish;
      if (lbl_take) begin
        cnt_ff <= lbl_pos + 3'd1;
      end
      if (take_first) begin
        chan_ff <= in_channel;
        cw_seen_ff <= 1'b0;
      end
      if (stack_end) begin
        depth_ff <= lbl_pos + 3'd1;
      end else if (stack_ovf) begin
        depth_ff <= 3'd0;
      end
      if (take_ctrl) begin
        cw_seen_ff <= 1'b1;
        cw_ok_ff <= (in_data[CW_CHECK_LSB +: 4] == 4'h0);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < MAX_DEPTH; i++) begin
        lbl_ff[i] <= 20'h00000;
      end
    end else if (lbl_take) begin
      lbl_ff[lbl_pos[1:0]] <= word.value;
    end
  end

  // Per-flow evaluation
  logic [NUM_FLOWS-1:0] flow_match;
  logic [NUM_FLOWS-1:0][4:0] flow_ofs;
  logic [NUM_FLOWS-1:0] group_vec, en_vec, chan_vec, depth_vec, cw_vec;

  for (genvar f = 0; f < NUM_FLOWS; f++) begin : g_flow
    flow_cfg_s c;
    logic [MAX_DEPTH-1:0] pass;
    assign c = flow_cfg_ff[f];
    assign en_vec[f] = c.enable;
    assign cw_vec[f] = c.cw_exp;
    assign group_vec[f] = c.grp_b;
    assign chan_vec[f] = c.chan_mask[chan_ff];
    assign cw_need_vec[f] = c.enable & c.cw_exp & c.chan_mask[ch_now];
    assign depth_vec[f] = (depth_ff != 3'd0) &
                          c.depth_mask[depth_ff[1:0] - 2'd1];
    for (genvar p = 0; p < MAX_DEPTH; p++) begin : g_pair
      logic [2:0] idx;
      logic present;
      logic [19:0] lv;
      logic [19:0] lo;
      logic [19:0] hi;
      // End reference aligns pair 3 with the bottom label
      assign idx = c.ref_end ? depth_ff + 3'(p) - 3'd4 : 3'(p);
      assign present = c.ref_end ? (depth_ff + 3'(p) >= 3'd4) :
                                   (depth_ff > 3'(p));
      assign lv = lbl_ff[idx[1:0]];
      assign lo = range_ff[{3'(f), 2'(p), 1'b0}];
      assign hi = range_ff[{3'(f), 2'(p), 1'b1}];
      // Absent labels count as passing
      assign pass[p] = ~present | ~range_en_ff |
                       ((lv >= lo) & (lv <= hi));
    end
    assign flow_match[f] = c.enable & chan_vec[f] & depth_vec[f] & (&pass) &
                           (~c.cw_exp | (cw_seen_ff & cw_ok_ff));
    assign flow_ofs[f] = {depth_ff, 2'b00} +
                         (c.cw_exp ? 5'd4 : 5'd0);
  end

  result_s nxt_res;
  assign nxt_res = '{offset: flow_ofs, depth: depth_ff, ptr_b: ptr_b_ff,
                     ptr_a: ptr_a_ff, group_b: group_vec,
                     match: flow_match};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_ff <= '0;
      res_valid_ff <= 1'b0;
    end else begin
      res_valid_ff <= eval_ff;
      if (eval_ff) begin
        res_ff <= nxt_res;
      end
    end
  end

  assign result = res_ff;
  assign result_valid = res_valid_ff;

  // Register decode
  logic aw_hs, w_hs, do_wr, nxt_aw_got, nxt_w_got;
  logic wr_global, wr_flow, wr_range, wr_hit;
  logic [31:0] glob_word, status_word, wr_old, wr_new;
  logic ar_hs, nxt_rvalid;
  logic rd_global, rd_status, rd_flow, rd_range, rd_hit;
  logic [31:0] rd_word;

  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign nxt_aw_got = (aw_got_ff & ~do_wr) | aw_hs;
  assign nxt_w_got = (w_got_ff & ~do_wr) | w_hs;
  assign wr_global = (waddr_ff[11:2] == GLOBAL_OFS[11:2]);
  assign wr_flow = (waddr_ff[11:5] == FLOW_CFG_BASE[11:5]);
  assign wr_range = (waddr_ff[11:8] == RANGE_BASE[11:8]);
  assign wr_hit = wr_global | wr_flow | wr_range;
  // Shared fields live in one word; per-flow fields stay in flow words
  assign glob_word = (32'(ptr_a_ff) << PTR_A_LSB) |
                     (32'(ptr_b_ff) << PTR_B_LSB) |
                     (32'(range_en_ff) << RANGE_EN_BIT);
  assign status_word = (32'(res_ff.depth) << ST_DEPTH_LSB) |
                       (32'(res_ff.match) << ST_MATCH_LSB) |
                       (32'(state_ff != ST_IDLE) << ST_BUSY_BIT);
  assign wr_old = wr_global ? glob_word :
                  wr_flow ? 32'(flow_cfg_ff[waddr_ff[4:2]]) :
                  32'(range_ff[waddr_ff[7:2]]);
  assign wr_new = strb_merge(wr_old, wdata_ff, wstrb_ff);
  assign ar_hs = s_axi_arvalid & arready_ff;
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
  assign rd_global = (s_axi_araddr[11:2] == GLOBAL_OFS[11:2]);
  assign rd_status = (s_axi_araddr[11:2] == STATUS_OFS[11:2]);
  assign rd_flow = (s_axi_araddr[11:5] == FLOW_CFG_BASE[11:5]);
  assign rd_range = (s_axi_araddr[11:8] == RANGE_BASE[11:8]);
  assign rd_hit = rd_global | rd_status | rd_flow | rd_range;
  assign rd_word = rd_global ? glob_word :
                   rd_status ? status_word :
                   rd_flow ? 32'(flow_cfg_ff[s_axi_araddr[4:2]]) :
                   rd_range ? 32'(range_ff[s_axi_araddr[7:2]]) : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= ~nxt_aw_got;
      wready_ff <= ~nxt_w_got;
      bvalid_ff <= do_wr | (bvalid_ff & ~s_axi_bready);
      if (aw_hs) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_a_ff <= GLOBAL_RST[PTR_A_LSB +: 3];
      ptr_b_ff <= GLOBAL_RST[PTR_B_LSB +: 3];
      range_en_ff <= GLOBAL_RST[RANGE_EN_BIT];
      for (int i = 0; i < NUM_FLOWS; i++) begin
        flow_cfg_ff[i] <= flow_cfg_s'(FLOW_CFG_RST[FLOW_CFG_W-1:0]);
      end
      for (int i = 0; i < NUM_FLOWS*MAX_DEPTH*2; i++) begin
        range_ff[i] <= i[0] ? RANGE_HIGH_RST : RANGE_LOW_RST;
      end
    end else if (do_wr) begin
      if (wr_global) begin
        ptr_a_ff <= wr_new[PTR_A_LSB +: 3];
        ptr_b_ff <= wr_new[PTR_B_LSB +: 3];
        range_en_ff <= wr_new[RANGE_EN_BIT];
      end
      if (wr_flow) begin
        flow_cfg_ff[waddr_ff[4:2]] <= flow_cfg_s'(wr_new[FLOW_CFG_W-1:0]);
      end
      if (wr_range) begin
        range_ff[waddr_ff[7:2]] <= wr_new[19:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_plain_end;
    stack_end && !need_cw;
  endsequence
  sequence s_cw_end;
    stack_end && need_cw;
  endsequence

  a_bottom_result: assert property (s_plain_end |-> ##2 result_valid)
    else $error("No result two cycles after bottom label");
  // No result may leave before the awaited control word
  a_cw_wait: assert property (s_cw_end |=>
      state_ff == ST_CTRL ##1 !result_valid)
    else $error("Result issued before control word");
  a_cw_nibble: assert property (take_ctrl &&
      in_data[CW_CHECK_LSB +: 4] != 4'h0 |->
      ##2 ((result.match & cw_vec) == '0))
    else $error("Flow matched with bad control word");
  // Next stack may already have moved depth and channel; use eval cycle
  a_depth_ok: assert property (result_valid |->
      ((result.match & ~$past(depth_vec)) == '0) && (result.match == '0 ||
      (result.depth >= 3'd1 && result.depth <= 3'd4)))
    else $error("Match with disallowed depth");
  a_flow_en: assert property (result_valid |->
      (result.match & ~$past(en_vec)) == '0)
    else $error("Disabled flow matched");
  a_chan_mask: assert property (result_valid |->
      (result.match & ~$past(chan_vec)) == '0)
    else $error("Masked channel matched");
  a_stack_ovf: assert property (stack_ovf |->
      ##2 (result_valid && result.match == '0 && result.depth == 3'd0))
    else $error("Oversized stack not rejected");
  a_next_offset: assert property (result_valid |->
      result.offset[0] == ({result.depth, 2'b00} +
      (cw_vec[0] ? 5'd4 : 5'd0)))
    else $error("Next protocol offset wrong");
  a_label_count: assert property (take_first && !word.bos |=>
      cnt_ff == 3'd1 && state_ff == ST_LABEL)
    else $error("Label count did not start at one");

endmodule : mpls_label_stack_comparator

/* verif/upstream_stage_model.sv */
`timescale 1ns/10ps
module upstream_stage_model
  import label_cmp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Word stream towards the comparator
  output logic in_valid,
  output logic in_sop,
  output logic [$clog2(NUM_CHAN)-1:0] in_channel,
  output logic [31:0] in_data
);
  localparam int CHW = $clog2(NUM_CHAN);
  logic [CHW+32:0] q[$];
  logic [CHW+32:0] w;

  initial begin
    in_valid = 1'b0;
    in_sop = 1'b0;
    in_channel = '0;
    in_data = 32'h0000_0000;
  end

  // Only label words and plain control words, never an ACH header
  task automatic push(input logic s, input logic [CHW-1:0] c,
                      input logic [31:0] d);
    q.push_back({s, c, d});
  endtask : push

  // Back to back while queued; idle data toggles so stale words never match
  always @(posedge aclk) begin
    if (q.size() > 0) begin
      w = q.pop_front();
      in_valid <= 1'b1;
      in_sop <= w[CHW+32];
      in_channel <= w[CHW+31:32];
      in_data <= w[31:0];
    end else begin
      in_valid <= 1'b0;
      in_sop <= 1'b0;
      in_data <= ~in_data;
    end
  end
endmodule : upstream_stage_model

/* verif/test_mpls_label_stack_comparator.sv */
`timescale 1ns/10ps
module test_mpls_label_stack_comparator
  import label_cmp_pkg::*;
;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic in_valid, in_sop;
  logic [$clog2(NUM_CHAN)-1:0] in_channel;
  logic [31:0] in_data, rd;
  logic [1:0] rs;
  result_s result, r;
  logic result_valid;
  int n_fail = 0;
  int checks_done = 0;

  mpls_label_stack_comparator mpls_label_stack_comparator_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_valid(in_valid), .in_sop(in_sop), .in_channel(in_channel),
    .in_data(in_data), .result(result), .result_valid(result_valid)
  );

  upstream_stage_model upstream_stage_model_i (
    .aclk(aclk), .in_valid(in_valid), .in_sop(in_sop),
    .in_channel(in_channel), .in_data(in_data)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Responses always accepted, so bready and rready never toggle
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] exp);
    int t;
    logic ad, wd;
    t = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd) && t < 200) begin
      @(posedge aclk);
      t++;
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      t++;
    end while (bvalid !== 1'b1 && t < 200);
    chk("bresp", bresp, exp);
    if (t >= 200) n_fail++;
  endtask : wr

  task automatic rd_reg(input logic [11:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
    end while (arready !== 1'b1 && t < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      t++;
    end while (rvalid !== 1'b1 && t < 200);
    rd = rdata;
    rs = rresp;
    if (t >= 200) n_fail++;
  endtask : rd_reg

  task automatic lab(input logic s, input logic c, input logic [19:0] v,
                     input logic b);
    upstream_stage_model_i.push(s, c, {v, 3'h0, b, 8'h40});
  endtask : lab

  task automatic wait_res();
    int t;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (result_valid !== 1'b1 && t < 100);
    r = result;
    if (t >= 100) n_fail++;
  endtask : wait_res

  task automatic t_reset_values();
    rd_reg(GLOBAL_OFS);
    chk("global", rd, GLOBAL_RST);
    rd_reg(FLOW_CFG_BASE + 12'h014);
    chk("flow5", rd, FLOW_CFG_RST);
    rd_reg(RANGE_BASE + 12'h004);
    chk("high0", rd, {12'h000, RANGE_HIGH_RST});
    rd_reg(12'h800);
    chk("unmapped", {rd[29:0], rs}, {30'h0, RESP_SLVERR});
    wr(STATUS_OFS, 32'h0000_00FF, RESP_SLVERR);
  endtask : t_reset_values

  task automatic t_config();
    wr(GLOBAL_OFS, 32'h0000_0135, RESP_OKAY);
    wr(FLOW_CFG_BASE, 32'h0000_0121, RESP_OKAY);
    wr(FLOW_CFG_BASE + 12'h004, 32'h0000_01F7, RESP_OKAY);
    wr(FLOW_CFG_BASE + 12'h008, 32'h0000_0211, RESP_OKAY);
    wr(FLOW_CFG_BASE + 12'h00C, 32'h0000_01E9, RESP_OKAY);
    wr(RANGE_BASE, 32'h0001_2345, RESP_OKAY);
    wr(RANGE_BASE + 12'h004, 32'h0001_2345, RESP_OKAY);
    wr(RANGE_BASE + 12'h078, 32'h0000_0ABC, RESP_OKAY);
    wr(RANGE_BASE + 12'h07C, 32'h0000_0ABC, RESP_OKAY);
    rd_reg(FLOW_CFG_BASE + 12'h004);
    chk("flow1", rd, 32'h0000_01F7);
  endtask : t_config

  // Two labels plus a clean control word on channel 0
  task automatic t_two_labels();
    lab(1'b1, 1'b0, 20'h12345, 1'b0);
    lab(1'b0, 1'b0, 20'h00ABC, 1'b1);
    upstream_stage_model_i.push(1'b0, 1'b0, 32'h0123_4567);
    wait_res();
    chk("depth", r.depth, 32'h2);
    chk("match", r.match, 32'h0B);
    chk("grp", r.group_b, 32'h02);
    chk("ptrs", {r.ptr_b, r.ptr_a}, 32'h1D);
    chk("ofs0", r.offset[0], 32'h8);
    chk("ofs1", r.offset[1], 32'hC);
  endtask : t_two_labels

  // Out of range top and end labels, control word with nonzero nibble
  task automatic t_failures();
    lab(1'b1, 1'b0, 20'h12346, 1'b0);
    lab(1'b0, 1'b0, 20'h00ABD, 1'b1);
    upstream_stage_model_i.push(1'b0, 1'b0, 32'hF000_0000);
    wait_res();
    chk("match", r.match, 32'h00);
  endtask : t_failures

  // Depth three, then a one-label stack on channel 1 right behind it
  task automatic t_back_to_back();
    lab(1'b1, 1'b0, 20'h12345, 1'b0);
    lab(1'b0, 1'b0, 20'h00001, 1'b0);
    lab(1'b0, 1'b0, 20'h00ABD, 1'b1);
    upstream_stage_model_i.push(1'b0, 1'b0, 32'h0000_0000);
    lab(1'b1, 1'b1, 20'h00007, 1'b1);
    wait_res();
    chk("depth", r.depth, 32'h3);
    chk("match", r.match, 32'h02);
    chk("ofs1", r.offset[1], 32'h10);
    wait_res();
    chk("depth", r.depth, 32'h1);
    chk("match", r.match, 32'h04);
    chk("ofs2", r.offset[2], 32'h4);
  endtask : t_back_to_back

  task automatic t_overflow();
    lab(1'b1, 1'b0, 20'h00001, 1'b0);
    lab(1'b0, 1'b0, 20'h00002, 1'b0);
    lab(1'b0, 1'b0, 20'h00003, 1'b0);
    lab(1'b0, 1'b0, 20'h00004, 1'b0);
    wait_res();
    chk("depth", r.depth, 32'h0);
    chk("match", r.match, 32'h00);
  endtask : t_overflow

  // Shared match mode off: labels no longer checked for any flow
  task automatic t_match_mode();
    wr(GLOBAL_OFS, 32'h0000_0035, RESP_OKAY);
    lab(1'b1, 1'b0, 20'h12346, 1'b0);
    lab(1'b0, 1'b0, 20'h00ABD, 1'b1);
    upstream_stage_model_i.push(1'b0, 1'b0, 32'h0000_0000);
    wait_res();
    chk("match", r.match, 32'h0B);
    rd_reg(STATUS_OFS);
    chk("status", rd, 32'h0000_0B02);
  endtask : t_match_mode

  initial begin
    #80000;
    n_fail++;
    stop_test();
  end

  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_values();
    t_config();
    t_two_labels();
    t_failures();
    t_back_to_back();
    t_overflow();
    t_match_mode();
    stop_test();
  end
endmodule : test_mpls_label_stack_comparator
